//--- rtl/rgb_blink_pkg.sv
// Constants, field layouts and types for the RGB blink timing control block.
// Assumes a 20 MHz system clock; the link side only delivers register writes.
package rgb_blink_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
  // Flash step is one 256th of the 0.128 s period unit
  localparam int STEP_US         = 500;
  localparam int STEP_CYC        = STEP_US * CLK_PER_US;
  // Quiet time after the last SDA rise before sleep
  localparam int SLEEP_DELAY_US  = 600;
  localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * CLK_PER_US;
  // One level step of the fastest ramp scale (128 ms / 256 / 8)
  localparam int RAMP_UNIT_NS    = 62_500;
  localparam int RAMP_UNIT_CYC   = RAMP_UNIT_NS * CLK_PER_US / 1000;
  // One level step of the 2 ms ramp at code zero, rounded down
  localparam int RAMP_ZERO_NS    = 7_812;
  localparam int RAMP_ZERO_CYC   = RAMP_ZERO_NS * CLK_PER_US / 1000;

  // ==========================================================================
  // Register addresses and reset values
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_TON_A  = 4'h2;
  localparam logic [3:0] ADDR_TON_B  = 4'h3;
  localparam logic [3:0] ADDR_CHSEL  = 4'h4;
  localparam logic [3:0] ADDR_RAMP   = 4'h5;

  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'h00;
  localparam logic [7:0] RST_TON     = 8'h01;
  localparam logic [7:0] RST_CHSEL   = 8'h00;
  localparam logic [7:0] RST_RAMP    = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MODE_MSB   = 2;
  localparam int EN_MSB     = 4;
  localparam int EN_LSB     = 3;
  localparam int SCALE_MSB  = 6;
  localparam int SCALE_LSB  = 5;
  localparam int PER_MSB    = 6;
  localparam int LINEAR_BIT = 7;
  localparam int RISE_MSB   = 3;
  localparam int FALL_MSB   = 7;
  localparam int FALL_LSB   = 4;
  localparam int CH3_HI     = 7;
  localparam int CH2_HI     = 6;
  localparam int CH3_MSB    = 5;
  localparam int CH3_LSB    = 4;
  localparam int CH2_MSB    = 3;
  localparam int CH2_LSB    = 2;
  localparam int CH1_MSB    = 1;

  // ==========================================================================
  // Codes
  // ==========================================================================
  localparam logic [2:0] PAT_ONE      = 3'h0;
  localparam logic [2:0] PAT_TWO      = 3'h1;
  localparam logic [2:0] PAT_THREE    = 3'h2;
  localparam logic [2:0] PAT_FOUR     = 3'h3;
  localparam logic [2:0] CMD_NOP      = 3'h4;
  localparam logic [2:0] CMD_RST_REGS = 3'h5;
  localparam logic [2:0] CMD_RST_LOGIC = 3'h6;
  localparam logic [2:0] CMD_RST_ALL  = 3'h7;

  localparam logic [1:0] EN_BOTH_HIGH = 2'h0;
  localparam logic [1:0] EN_SDA_TOGGLE = 2'h1;
  localparam logic [1:0] EN_SCL_HIGH  = 2'h2;
  localparam logic [1:0] EN_ALWAYS    = 2'h3;

  localparam logic [1:0] SCALE_X1     = 2'h0;
  localparam logic [1:0] SCALE_X2     = 2'h1;
  localparam logic [1:0] SCALE_X4     = 2'h2;
  localparam logic [5:0] MULT_X1      = 6'h08;
  localparam logic [5:0] MULT_X2      = 6'h10;
  localparam logic [5:0] MULT_X4      = 6'h20;
  localparam logic [5:0] MULT_FAST    = 6'h01;

  localparam logic [1:0] SEL_OFF      = 2'h0;
  localparam logic [1:0] SEL_ON       = 2'h1;
  localparam logic [1:0] SEL_LANE_ONE = 2'h2;

  localparam logic [7:0] LEVEL_MAX    = 8'hFF;
  localparam logic [7:0] LEVEL_HALF   = 8'h80;
  localparam int         SQ_SHIFT     = 7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } reg_write_s;

  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_QUIET = 2'b01,
    PWR_SLEEP = 2'b11
  } power_state_e;

endpackage : rgb_blink_pkg

//--- rtl/rgb_blink_timing_control.sv
// Timing core of a three channel RGB current sink: registers, flash timers,
// pattern lanes, ramps and the bus-line based sleep control.
// Assumes a serial slave on link_clk hands in whole register writes and that
// scl_pin/sda_pin are the raw bus pins, asynchronous to ref_clk.
//
// Behaviour
// - Control bits 2:0 select timing pattern
// - Codes 100 idle, 101/110/111 reset scopes
// - Enable 00: awake while SCL, SDA high
// - Enable 01: awake while SCL high, SDA toggles
// - Enable 10 follows SCL; 11 always awake
// - Sleep waits 600 us after SDA rise
// - Control bits 6:5 scale both ramp times; ramp code 0 is fixed
// - Flash period is (code+1) x 0.128 s
// - On time is code/256 of period
// - On time includes the ramp-up
// - Period bit 7 picks linear or S ramp
// - Channel three mode from bits 7,5,4
// - Channel two mode from bits 6,3,2
// - Channel one two-bit mode, no lane three
// - One shared period; overruns end at boundary
// - Ramp register: rise low, fall high nibble
`timescale 1ns/1ps
module rgb_blink_timing_control
  import rgb_blink_pkg::*;
#(
  parameter int STEP_LEN    = STEP_CYC,
  parameter int SLEEP_LEN   = SLEEP_DELAY_CYC,
  parameter int RAMP_UNIT   = RAMP_UNIT_CYC,
  parameter int RAMP_ZERO   = RAMP_ZERO_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  input  wire logic       link_rst_n,
  input  wire logic       wr_valid,
  input  wire reg_write_s wr_req,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data_q,
  output logic            sleep_q,
  output logic      [2:0] pattern_lane_q,
  output logic [2:0][7:0] sink_level_q
);

  if (STEP_LEN < 1 || STEP_LEN > 65535) $error("STEP_LEN out of range");
  if (SLEEP_LEN < 2 || SLEEP_LEN > 65535) $error("SLEEP_LEN out of range");
  if (RAMP_UNIT < 1 || RAMP_UNIT > 16383) $error("RAMP_UNIT out of range");
  if (RAMP_ZERO < 1 || RAMP_ZERO > 65535) $error("RAMP_ZERO out of range");

  // ==========================================================================
  // Link side: hold the write and flip a toggle
  // ==========================================================================
  logic       wr_tgl_q;
  reg_write_s wr_hold_q;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      wr_tgl_q  <= 1'b0;
      wr_hold_q <= '0;
    end else if (wr_valid) begin
      wr_tgl_q  <= ~wr_tgl_q;
      wr_hold_q <= wr_req;
    end
  end

  // ==========================================================================
  // Crossings into ref_clk
  // ==========================================================================
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic scl_s1_q, scl_s2_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= wr_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_pin;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= sda_pin;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  logic       wr_fire;
  logic [2:0] wr_cmd;
  logic       reg_clr;
  logic       logic_clr_q;
  logic       dev_clr_q;

  assign wr_fire = tgl_s2_q ^ tgl_s3_q;
  assign wr_cmd  = wr_hold_q.data[MODE_MSB:0];
  assign reg_clr = wr_fire && wr_hold_q.addr == ADDR_CTRL && wr_cmd >= CMD_RST_REGS;

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [7:0] ctrl_q, period_q, ton_a_q, ton_b_q, chsel_q, ramp_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || reg_clr) begin
      ctrl_q   <= RST_CTRL;
      period_q <= RST_PERIOD;
      ton_a_q  <= RST_TON;
      ton_b_q  <= RST_TON;
      chsel_q  <= RST_CHSEL;
      ramp_q   <= RST_RAMP;
    end else if (wr_fire) begin
      if (wr_hold_q.addr == ADDR_CTRL) begin
        if (wr_cmd == CMD_NOP) begin
          ctrl_q <= {wr_hold_q.data[7:MODE_MSB+1], ctrl_q[MODE_MSB:0]};
        end else begin
          ctrl_q <= wr_hold_q.data;
        end
      end else if (wr_hold_q.addr == ADDR_PERIOD) begin
        period_q <= wr_hold_q.data;
      end else if (wr_hold_q.addr == ADDR_TON_A) begin
        ton_a_q <= wr_hold_q.data;
      end else if (wr_hold_q.addr == ADDR_TON_B) begin
        ton_b_q <= wr_hold_q.data;
      end else if (wr_hold_q.addr == ADDR_CHSEL) begin
        chsel_q <= wr_hold_q.data;
      end else if (wr_hold_q.addr == ADDR_RAMP) begin
        ramp_q <= wr_hold_q.data;
      end
    end
  end

  // Wider reset scopes act one cycle after the command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      logic_clr_q <= 1'b0;
      dev_clr_q   <= 1'b0;
    end else begin
      logic_clr_q <= reg_clr && wr_cmd >= CMD_RST_LOGIC;
      dev_clr_q   <= reg_clr && wr_cmd == CMD_RST_ALL;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (rd_addr == ADDR_CTRL) begin
      rd_data_q <= ctrl_q;
    end else if (rd_addr == ADDR_PERIOD) begin
      rd_data_q <= period_q;
    end else if (rd_addr == ADDR_TON_A) begin
      rd_data_q <= ton_a_q;
    end else if (rd_addr == ADDR_TON_B) begin
      rd_data_q <= ton_b_q;
    end else if (rd_addr == ADDR_CHSEL) begin
      rd_data_q <= chsel_q;
    end else if (rd_addr == ADDR_RAMP) begin
      rd_data_q <= ramp_q;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  // ==========================================================================
  // Sleep control
  // ==========================================================================
  logic [15:0]  since_rise_q;
  logic         quiet;
  logic         awake_cond;
  power_state_e pwr_q;

  assign quiet = since_rise_q >= 16'(SLEEP_LEN - 1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || dev_clr_q) begin
      since_rise_q <= 16'h0000;
    end else if (sda_s2_q && !sda_s3_q) begin
      since_rise_q <= 16'h0000;
    end else if (!quiet) begin
      since_rise_q <= since_rise_q + 16'h0001;
    end
  end

  always_comb begin
    case (ctrl_q[EN_MSB:EN_LSB])
      EN_BOTH_HIGH:  awake_cond = scl_s2_q && sda_s2_q;
      EN_SDA_TOGGLE: awake_cond = scl_s2_q && !quiet;
      EN_SCL_HIGH:   awake_cond = scl_s2_q;
      default:       awake_cond = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || dev_clr_q) begin
      pwr_q <= PWR_AWAKE;
    end else begin
      case (pwr_q)
        PWR_AWAKE: if (!awake_cond) pwr_q <= PWR_QUIET;
        PWR_QUIET: begin
          if (awake_cond) pwr_q <= PWR_AWAKE;
          else if (quiet) pwr_q <= PWR_SLEEP;
        end
        PWR_SLEEP: if (awake_cond) pwr_q <= PWR_AWAKE;
        default:   pwr_q <= PWR_AWAKE;
      endcase
    end
  end

  assign sleep_q = (pwr_q == PWR_SLEEP);

  // ==========================================================================
  // Flash period: 256 steps of (code+1) x STEP_LEN cycles
  // ==========================================================================
  logic [23:0] step_len;
  logic [23:0] presc_q;
  logic [7:0]  phase_q;

  assign step_len = 24'((24'(period_q[PER_MSB:0]) + 24'h000001) * 24'(STEP_LEN));

  always_ff @(posedge ref_clk) begin
    if (!rst_n || logic_clr_q) begin
      presc_q <= 24'h000000;
      phase_q <= 8'h00;
    end else if (!sleep_q) begin
      if (presc_q >= step_len - 24'h000001) begin
        presc_q <= 24'h000000;
        phase_q <= phase_q + 8'h01;
      end else begin
        presc_q <= presc_q + 24'h000001;
      end
    end
  end

  // ==========================================================================
  // Pattern lanes and channel selection
  // ==========================================================================
  logic [8:0] ton_sum;
  logic [7:0] ton_diff;
  logic [2:0] lane;
  logic [2:0] chan_on;

  assign ton_sum  = {1'b0, ton_a_q} + {1'b0, ton_b_q};
  assign ton_diff = (ton_a_q > ton_b_q) ? ton_a_q - ton_b_q : ton_b_q - ton_a_q;

  always_comb begin
    lane[0] = phase_q < ton_a_q;
    lane[1] = phase_q < ton_b_q;
    case (ctrl_q[MODE_MSB:0])
      PAT_ONE:   lane[2] = lane[0];
      PAT_TWO:   lane[2] = lane[1];
      PAT_THREE: lane[2] = {1'b0, phase_q} < ton_sum;
      PAT_FOUR:  lane[2] = phase_q < ton_diff;
      default:   lane[2] = lane[0];
    endcase
  end

  function automatic logic pick(input logic [2:0] sel, input logic [2:0] ln);
    if (sel[2]) return ln[2];
    case (sel[1:0])
      SEL_OFF:      return 1'b0;
      SEL_ON:       return 1'b1;
      SEL_LANE_ONE: return ln[0];
      default:      return ln[1];
    endcase
  endfunction : pick

  always_comb begin
    chan_on[0] = pick({1'b0, chsel_q[CH1_MSB:0]}, lane);
    chan_on[1] = pick({chsel_q[CH2_HI], chsel_q[CH2_MSB:CH2_LSB]}, lane);
    chan_on[2] = pick({chsel_q[CH3_HI], chsel_q[CH3_MSB:CH3_LSB]}, lane);
    if (sleep_q) chan_on = 3'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || logic_clr_q) begin
      pattern_lane_q <= 3'h0;
    end else begin
      pattern_lane_q <= sleep_q ? 3'h0 : lane;
    end
  end

  // ==========================================================================
  // Ramps: one level step per ramp_len cycles
  // ==========================================================================
  function automatic logic [23:0] ramp_len(input logic [3:0] code, input logic [1:0] scale);
    logic [5:0] mult;
    mult = MULT_FAST;
    if (scale == SCALE_X1) mult = MULT_X1;
    else if (scale == SCALE_X2) mult = MULT_X2;
    else if (scale == SCALE_X4) mult = MULT_X4;
    if (code == 4'h0) return 24'(RAMP_ZERO);
    return 24'(24'(code) * 24'(mult) * 24'(RAMP_UNIT));
  endfunction : ramp_len

  function automatic logic [7:0] s_curve(input logic [7:0] lin);
    logic [15:0] sq;
    logic [7:0]  m;
    m  = (lin < LEVEL_HALF) ? lin : LEVEL_MAX - lin;
    sq = (16'(m) * 16'(m)) >> SQ_SHIFT;
    return (lin < LEVEL_HALF) ? sq[7:0] : LEVEL_MAX - sq[7:0];
  endfunction : s_curve

  logic [23:0] rise_len, fall_len;

  assign rise_len = ramp_len(ramp_q[RISE_MSB:0], ctrl_q[SCALE_MSB:SCALE_LSB]);
  assign fall_len = ramp_len(ramp_q[FALL_MSB:FALL_LSB], ctrl_q[SCALE_MSB:SCALE_LSB]);

  for (genvar i = 0; i < 3; i++) begin : g_ramp
    logic [23:0] rc_q;
    logic [7:0]  lin_q;
    logic [23:0] len;
    logic        moving;

    assign len    = chan_on[i] ? rise_len : fall_len;
    assign moving = chan_on[i] ? (lin_q != LEVEL_MAX) : (lin_q != 8'h00);

    // Ramp-up runs inside the on window and never stretches it
    always_ff @(posedge ref_clk) begin
      if (!rst_n || logic_clr_q) begin
        rc_q  <= 24'h000000;
        lin_q <= 8'h00;
      end else if (!moving) begin
        rc_q <= 24'h000000;
      end else if (rc_q >= len - 24'h000001) begin
        rc_q  <= 24'h000000;
        lin_q <= chan_on[i] ? lin_q + 8'h01 : lin_q - 8'h01;
      end else begin
        rc_q <= rc_q + 24'h000001;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_n || logic_clr_q) begin
        sink_level_q[i] <= 8'h00;
      end else begin
        sink_level_q[i] <= period_q[LINEAR_BIT] ? lin_q : s_curve(lin_q);
      end
    end
  end

endmodule : rgb_blink_timing_control

//--- verification/host_link_model.sv
// Host stand-in: hands whole register writes to the block on the link clock.
// Assumes the block takes wr_req on a rising link_clk edge with wr_valid high.
`timescale 1ns/1ps
module host_link_model
  import rgb_blink_pkg::*;
(
  input  wire logic link_clk,
  output logic       wr_valid,
  output reg_write_s wr_req
);
  initial begin
    wr_valid = 1'b0;
    wr_req   = '0;
  end

  // =========================================================================
  // One write, then a gap long enough for the crossing (gap adds slowness)
  // =========================================================================
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data, input int gap);
    @(posedge link_clk);
    wr_valid <= 1'b1;
    wr_req   <= '{addr: addr, data: (addr == ADDR_CTRL) ? (data & 8'h7F) : data};
    @(posedge link_clk);
    wr_valid <= 1'b0;
    wr_req   <= ~wr_req;
    repeat (8 + gap) @(posedge link_clk);
  endtask : write_reg
endmodule : host_link_model

//--- verification/rgb_blink_chk.sv
// Port checker for the RGB blink timing core.
// Assumes register state is seen only through rd_addr and rd_data_q.
`timescale 1ns/1ps
module rgb_blink_chk
  import rgb_blink_pkg::*;
#(
  parameter int SLEEP_LEN = SLEEP_DELAY_CYC
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            link_clk,
  input wire logic            link_rst_n,
  input wire logic            wr_valid,
  input wire reg_write_s      wr_req,
  input wire logic            scl_pin,
  input wire logic            sda_pin,
  input wire logic [3:0]      rd_addr,
  input wire logic [7:0]      rd_data_q,
  input wire logic            sleep_q,
  input wire logic [2:0]      pattern_lane_q,
  input wire logic [2:0][7:0] sink_level_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // =========================================================================
  // Cycles since the last raw SDA rise, saturating
  // =========================================================================
  int   quiet_q;
  logic sda_d_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      quiet_q <= SLEEP_LEN;
      sda_d_q <= 1'b1;
    end else begin
      sda_d_q <= sda_pin;
      if (sda_pin && !sda_d_q) begin
        quiet_q <= 0;
      end else if (quiet_q < SLEEP_LEN) begin
        quiet_q <= quiet_q + 1;
      end
    end
  end

  // =========================================================================
  // Properties
  // =========================================================================
  a_sleep_lanes_off: assert property (sleep_q [*2] |-> pattern_lane_q == 3'h0)
    else $error("lanes active during sleep");
  a_unmapped_read_zero: assert property ((rd_addr > ADDR_RAMP) [*2] |-> rd_data_q == 8'h00)
    else $error("unmapped address read nonzero");
  a_pat_one_lane: assert property (
    (rd_addr == ADDR_CTRL && rd_data_q[MODE_MSB:0] == PAT_ONE) [*4] |-> pattern_lane_q[2] == pattern_lane_q[0])
    else $error("lane three differs from lane one");
  a_pat_two_lane: assert property (
    (rd_addr == ADDR_CTRL && rd_data_q[MODE_MSB:0] == PAT_TWO) [*4] |-> pattern_lane_q[2] == pattern_lane_q[1])
    else $error("lane three differs from lane two");
  a_ton_zero_lane: assert property (
    (rd_addr == ADDR_TON_A && rd_data_q == 8'h00) [*4] |-> !pattern_lane_q[0])
    else $error("lane one high with zero on time");
  a_off_level_hold: assert property (
    (rd_addr == ADDR_CHSEL && rd_data_q == 8'h00) [*4] ##0 sink_level_q == '0 |=> sink_level_q == '0)
    else $error("level rose with all channels off");
  a_always_awake: assert property (
    (rd_addr == ADDR_CTRL && rd_data_q[EN_MSB:EN_LSB] == EN_ALWAYS) [*4] |-> !sleep_q)
    else $error("sleep with enable always on");
  a_scl_wake: assert property (
    (rd_addr == ADDR_CTRL && rd_data_q[EN_MSB:EN_LSB] == EN_SCL_HIGH && scl_pin) [*8] |-> !sleep_q)
    else $error("sleep while scl high");
  a_both_high_awake: assert property (
    (rd_addr == ADDR_CTRL && rd_data_q[EN_MSB:EN_LSB] == EN_BOTH_HIGH && scl_pin && sda_pin) [*8] |-> !sleep_q)
    else $error("sleep while both lines high");
  a_sleep_after_quiet: assert property ($rose(sleep_q) |-> quiet_q >= SLEEP_LEN - 1)
    else $error("sleep entered too soon after sda rise");

  c_sleep_entered: cover property ($rose(sleep_q));
  c_all_lanes: cover property (pattern_lane_q == 3'h7);
  c_full_level: cover property (sink_level_q[0] == LEVEL_MAX);
endmodule : rgb_blink_chk

bind rgb_blink_timing_control rgb_blink_chk #(.SLEEP_LEN(SLEEP_LEN)) i_rgb_blink_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n), .wr_valid(wr_valid),
  .wr_req(wr_req), .scl_pin(scl_pin), .sda_pin(sda_pin), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
  .sleep_q(sleep_q), .pattern_lane_q(pattern_lane_q), .sink_level_q(sink_level_q)
);

//--- verification/tb_top.sv
// Self-checking bench for the RGB blink timing core and its host write model.
// Assumes shortened step, sleep and ramp parameters; expectations use them.
`timescale 1ns/1ps
module tb_top;
  import rgb_blink_pkg::*;
  localparam int STEP = 4;
  localparam int SLP  = 20;
  // Each case: {enable, scl, sda, toggle, expected sleep}
  localparam logic [5:0] SLEEP_CASES [8] = '{6'h0C, 6'h09, 6'h05, 6'h1E, 6'h1D, 6'h28, 6'h25, 6'h30};

  logic            ref_clk = 1'b0;
  logic            link_clk = 1'b0;
  logic            rst_n;
  logic            link_rst_n;
  logic            scl_pin;
  logic            sda_pin;
  logic            sda_toggle = 1'b0;
  logic [3:0]      rd_addr;
  logic            wr_valid;
  reg_write_s      wr_req;
  logic [7:0]      rd_data_q;
  logic            sleep_q;
  logic [2:0]      pattern_lane_q;
  logic [2:0][7:0] sink_level_q;
  logic [7:0]      regs [6];
  int              num_errors = 0;
  int              cmp_count = 0;
  int              seed = 46;

  always #25 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    if (sda_toggle) begin
      sda_pin <= ~sda_pin;
    end
  end

  rgb_blink_timing_control #(.STEP_LEN(STEP), .SLEEP_LEN(SLP), .RAMP_UNIT(1), .RAMP_ZERO(1)) i_rgb_blink_timing_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n), .wr_valid(wr_valid),
    .wr_req(wr_req), .scl_pin(scl_pin), .sda_pin(sda_pin), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
    .sleep_q(sleep_q), .pattern_lane_q(pattern_lane_q), .sink_level_q(sink_level_q));
  host_link_model i_host_link_model (.link_clk(link_clk), .wr_valid(wr_valid), .wr_req(wr_req));

  // =========================================================================
  // Compare, access and closing tasks
  // =========================================================================
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: value %h, model %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      num_errors++;
      $display("unexpected at %0t: count %0d, model %0d", $time, got, exp);
    end
  endtask : check_cnt

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == ADDR_CTRL) ? (d & 8'h7F) : d;
    i_host_link_model.write_reg(a, v, {$random(seed)} % 4);
    if (a == ADDR_CTRL && v[2:0] == CMD_NOP) begin
      regs[0] = {v[7:3], regs[0][2:0]};
    end else if (a == ADDR_CTRL && v[2]) begin
      regs = '{RST_CTRL, RST_PERIOD, RST_TON, RST_TON, RST_CHSEL, RST_RAMP};
    end else if (a <= ADDR_RAMP) begin
      regs[a] = v;
    end
    repeat (6) @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    rd_addr <= a;
    repeat (5) @(posedge ref_clk);
    check8(rd_data_q, (a <= ADDR_RAMP) ? regs[a] : 8'h00);
  endtask : rd

  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end

  // =========================================================================
  // Main sequence
  // =========================================================================
  initial begin
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    rd_addr = ADDR_CTRL;
    regs = '{RST_CTRL, RST_PERIOD, RST_TON, RST_TON, RST_CHSEL, RST_RAMP};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    link_rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
    end
    for (int c = 4; c < 8; c++) begin
      for (int a = 1; a < 6; a++) begin
        wr(4'(a), 8'($random(seed)));
      end
      wr(ADDR_CTRL, {5'($random(seed)), 3'(c)});
      for (int a = 0; a < 6; a++) begin
        rd(4'(a));
      end
    end
    repeat (12) begin
      logic [3:0] a;
      a = 4'({$random(seed)} % 7);
      wr(a, 8'($random(seed)));
      rd(a);
    end
    for (int p = 0; p < 4; p++) begin
      int ta, tb, l3, n;
      int hits [3];
      ta = 1 + {$random(seed)} % 255;
      tb = {$random(seed)} % 256;
      l3 = (p == 0) ? ta : (p == 1) ? tb : (p == 2) ? ((ta + tb > 256) ? 256 : ta + tb) : ((ta > tb) ? ta - tb : tb - ta);
      wr(ADDR_TON_A, 8'(ta));
      wr(ADDR_TON_B, 8'(tb));
      wr(ADDR_PERIOD, 8'(p));
      wr(ADDR_CTRL, {3'b000, EN_ALWAYS, 3'(p)});
      rd_addr <= ADDR_CTRL;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (pattern_lane_q[0] !== 1'b0 && n < 9000);
      do begin @(posedge ref_clk); n++; end while (pattern_lane_q[0] !== 1'b1 && n < 9000);
      hits = '{0, 0, 0};
      for (int k = 0; k < (p + 1) * STEP * 256; k++) begin
        for (int b = 0; b < 3; b++) hits[b] += pattern_lane_q[b];
        @(posedge ref_clk);
      end
      check_cnt(hits[0], ta * (p + 1) * STEP);
      check_cnt(hits[1], tb * (p + 1) * STEP);
      check_cnt(hits[2], l3 * (p + 1) * STEP);
    end
    wr(ADDR_PERIOD, 8'h80);
    wr(ADDR_TON_A, 8'h00);
    rd_addr <= ADDR_TON_A;
    wr(ADDR_TON_B, 8'hFF);
    wr(ADDR_RAMP, 8'h00);
    wr(ADDR_CTRL, {3'b000, EN_ALWAYS, PAT_TWO});
    for (int m = 0; m < 8; m++) begin
      logic [2:0] mm;
      logic       on;
      mm = 3'(m);
      on = mm[2] | mm[0];
      wr(ADDR_CHSEL, {mm[2], mm[2], mm[1:0], mm[1:0], mm[1:0]});
      repeat (400) @(posedge ref_clk);
      check8(sink_level_q[0] | (mm[0] ? 8'h1F : 8'h00), mm[0] ? LEVEL_MAX : 8'h00);
      check8(sink_level_q[1] | (on ? 8'h1F : 8'h00), on ? LEVEL_MAX : 8'h00);
      check8(sink_level_q[2] | (on ? 8'h1F : 8'h00), on ? LEVEL_MAX : 8'h00);
    end
    wr(ADDR_RAMP, 8'h01);
    for (int s = 0; s < 4; s++) begin
      int span;
      wr(ADDR_CHSEL, 8'h00);
      rd_addr <= ADDR_CHSEL;
      wr(ADDR_CTRL, {1'b0, 2'(s), EN_ALWAYS, PAT_ONE});
      repeat (300) @(posedge ref_clk);
      span = 0;
      fork
        wr(ADDR_CHSEL, 8'h01);
        for (int k = 0; k < 9000 && sink_level_q[0] !== LEVEL_MAX; k++) begin
          span += (sink_level_q[0] !== 8'h00);
          @(posedge ref_clk);
        end
      join
      check_cnt(span, 254 * ((s == 3) ? 1 : (8 << s)));
    end
    begin
      int mid;
      mid = 0;
      wr(ADDR_PERIOD, 8'h00);
      wr(ADDR_CHSEL, 8'h00);
      repeat (300) @(posedge ref_clk);
      fork
        wr(ADDR_CHSEL, 8'h01);
        for (int k = 0; k < 900 && sink_level_q[0] !== LEVEL_MAX; k++) begin
          mid += (sink_level_q[0] inside {[8'h01:8'h7F]});
          @(posedge ref_clk);
        end
      join
      check_cnt(mid, 116);
    end
    rd_addr <= ADDR_CTRL;
    for (int i = 0; i < 8; i++) begin
      logic [5:0] c;
      c = SLEEP_CASES[i];
      sda_toggle <= 1'b0;
      @(posedge ref_clk);
      scl_pin <= 1'b1;
      sda_pin <= 1'b1;
      wr(ADDR_CTRL, {3'b000, c[5:4], PAT_ONE});
      repeat (SLP + 20) @(posedge ref_clk);
      scl_pin <= c[3];
      sda_pin <= c[2];
      sda_toggle <= c[1];
      repeat (SLP + 20) @(posedge ref_clk);
      check8({7'h00, sleep_q}, {7'h00, c[0]});
    end
    conclude();
  end
endmodule : tb_top
